// File: hw/ldd_defs.vh
// constants of the capacity led display driver
`ifndef LDD_DEFS_VH
`define LDD_DEFS_VH

// ****************************************************************
// clock and timing
// ****************************************************************
`define LDD_CLK_HZ 125000000
`define LDD_MUX_HZ 100
`define LDD_MUX_CYC (`LDD_CLK_HZ / `LDD_MUX_HZ)
`define LDD_MUX_ON_PCT 30
`define LDD_SHOW_MS 4000
`define LDD_SHOW_CYC (`LDD_SHOW_MS * (`LDD_CLK_HZ / 1000))
`define LDD_BLINK_HZ 4
`define LDD_BLINK_HALF_CYC (`LDD_CLK_HZ / (2 * `LDD_BLINK_HZ))

// ****************************************************************
// scaling
// ****************************************************************
`define LDD_SEGS 5
`define LDD_FS_MV 1200
`define LDD_FINAL_DROP_MV 25
`define LDD_VSCALE 256
`define LDD_COLD_SHIFT 3

// ****************************************************************
// register map
// ****************************************************************
`define LDD_REG_THRESH 8'h00
`define LDD_REG_CHGTHR 8'h04
`define LDD_REG_STATUS 8'h08
`define LDD_REG_IRQ_STAT 8'h0C
`define LDD_REG_IRQ_MASK 8'h10
`define LDD_THRESH_RST 8'hA2
`define LDD_CHGTHR_RST 16'h0002

// status fields
`define LDD_ST_SHOW 0
`define LDD_ST_FIRST 1
`define LDD_ST_FINAL 2
`define LDD_ST_CHG 3
`define LDD_ST_MODE_LO 4
`define LDD_ST_PAT_LO 8
`define LDD_ST_TEMP_COMPENSATED_CHARGE_LO 16

// interrupt bits
`define LDD_IRQ_FIRST 0
`define LDD_IRQ_FINAL 1
`define LDD_IRQ_TIMEOUT 2
`define LDD_IRQ_W 3

`endif

// File: hw/ldd_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ldd_sync #(
  parameter W = 2
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // asynchronous input and filtered result
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r;
    end
  end

endmodule

// File: hw/ldd_top.v
// capacity led bar driver with apb registers
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "ldd_defs.vh"
module ldd_top #(
  parameter MUX_CYC = `LDD_MUX_CYC,
  parameter SHOW_CYC = `LDD_SHOW_CYC,
  parameter BLINK_HALF_CYC = `LDD_BLINK_HALF_CYC
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // display request pin, sensed as two comparator levels
  input wire display_request_input_req_high,
  input wire display_request_input_req_low,
  // gauge values from the same clock domain
  input wire [15:0] charge_sense,
  input wire [7:0] battery_voltage,
  input wire [7:0] learned_full_capacity,
  input wire [7:0] rate_compensated_charge,
  input wire temp_below_10c,
  // led pins
  output reg [4:0] led_segment_outputs,
  output reg led_common_drive,
  output reg led_common_oe_n,
  // shown value and interrupt
  output reg [7:0] temp_compensated_charge,
  output reg irq
);

  localparam MUX_ON_CYC = (MUX_CYC * `LDD_MUX_ON_PCT) / 100;
  localparam MUX_HALF_CYC = MUX_CYC / 2;

  // timed-show states
  localparam ST_IDLE = 3'b001;
  localparam ST_SHOW = 3'b010;
  localparam ST_HOLD = 3'b100;

  // ****************************************************************
  // registers and state
  // ****************************************************************
  reg [7:0] empty_threshold_setting_r;
  reg [15:0] charge_detect_threshold_r;
  reg [`LDD_IRQ_W-1:0] irq_stat_r;
  reg [`LDD_IRQ_W-1:0] irq_mask_r;
  reg first_empty_flag_r;
  reg final_empty_flag_r;
  reg charging_r;
  reg [4:0] pattern_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [31:0] show_cnt_r;
  reg [31:0] mux_cnt_r;
  reg [31:0] blink_cnt_r;
  reg blink_on_r;
  reg show_r;
  reg timeout_ev;
  reg [4:0] pattern_nxt;
  reg [4:0] bank_mask;
  reg show_nxt;
  reg [31:0] rd_data;
  reg rd_ok;
  integer k;

  wire [1:0] req_sync;
  wire req_high = req_sync[1];
  wire req_low = req_sync[0] & ~req_sync[1];
  wire req_float = ~req_sync[0] & ~req_sync[1];
  wire apb_done = psel & penable & pready;
  wire apb_wr = apb_done & pwrite;

  // ****************************************************************
  // request pin synchronisation
  // ****************************************************************
  ldd_sync #(
    .W(2)
  ) u_req_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din({display_request_input_req_high, display_request_input_req_low}),
    .dout(req_sync)
  );

  // ****************************************************************
  // compensation, trip points and segment count
  // ****************************************************************
  wire [7:0] cold_loss = rate_compensated_charge >> `LDD_COLD_SHIFT;
  wire [7:0] temp_compensated_charge_nxt = temp_below_10c ? (rate_compensated_charge - cold_loss)
                                       : rate_compensated_charge;
  wire [18:0] vsb_mv = battery_voltage * 11'd`LDD_FS_MV;
  wire [18:0] first_empty_flag_mv = empty_threshold_setting_r * 11'd`LDD_FS_MV;
  wire [18:0] drop_mv = 19'd`LDD_FINAL_DROP_MV * 19'd`LDD_VSCALE;
  wire [10:0] temp_compensated_charge_x5 = {1'b0, temp_compensated_charge, 2'b00}
                        + {3'b000, temp_compensated_charge};

  always @*
  begin
    // segment k lights when 5*charge exceeds k*capacity
    pattern_nxt = 5'b0_0000;
    for (k = 0; k < `LDD_SEGS; k = k + 1)
      pattern_nxt[k] = (temp_compensated_charge_x5 > k[2:0] * {3'b000, learned_full_capacity});
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      temp_compensated_charge <= 8'h00;
      first_empty_flag_r <= 1'b0;
      final_empty_flag_r <= 1'b0;
      charging_r <= 1'b0;
      pattern_r <= 5'b0_0000;
    end
    else
    begin
      // only the shown copy is derated; the charge inputs stay untouched
      temp_compensated_charge <= temp_compensated_charge_nxt;
      first_empty_flag_r <= (battery_voltage < empty_threshold_setting_r);
      final_empty_flag_r <= (first_empty_flag_mv > drop_mv) && (vsb_mv < first_empty_flag_mv - drop_mv);
      charging_r <= ($signed(charge_sense) > $signed(charge_detect_threshold_r));
      pattern_r <= pattern_nxt;
    end
  end

  // ****************************************************************
  // display request modes
  // ****************************************************************
  always @*
  begin
    state_nxt = state_r;
    timeout_ev = 1'b0;
    case (state_r)
      ST_IDLE:
        if (req_low)
          state_nxt = ST_SHOW;
      ST_SHOW:
        if (!req_low && !req_float && req_high)
          state_nxt = ST_IDLE;
        else if (show_cnt_r >= SHOW_CYC - 1)
        begin
          timeout_ev = 1'b1;
          state_nxt = req_low ? ST_HOLD : ST_IDLE;
        end
      ST_HOLD:
        if (!req_low)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @*
  begin
    if (final_empty_flag_r || req_high)
      show_nxt = 1'b0;
    else if (req_float)
      show_nxt = charging_r;
    else
      show_nxt = (state_r == ST_SHOW);
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      show_cnt_r <= 32'h0000_0000;
      show_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      show_cnt_r <= (state_r == ST_SHOW) ? show_cnt_r + 32'h0000_0001 : 32'h0000_0000;
      show_r <= show_nxt;
    end
  end

  // ****************************************************************
  // bank multiplexing and low-battery blink
  // ****************************************************************
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      mux_cnt_r <= 32'h0000_0000;
      blink_cnt_r <= 32'h0000_0000;
      blink_on_r <= 1'b1;
    end
    else
    begin
      mux_cnt_r <= (mux_cnt_r >= MUX_CYC - 1) ? 32'h0000_0000
                                              : mux_cnt_r + 32'h0000_0001;
      if (!first_empty_flag_r)
      begin
        blink_cnt_r <= 32'h0000_0000;
        blink_on_r <= 1'b1;
      end
      else if (blink_cnt_r >= BLINK_HALF_CYC - 1)
      begin
        blink_cnt_r <= 32'h0000_0000;
        blink_on_r <= ~blink_on_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  always @*
  begin
    bank_mask = 5'b0_0000;
    if (mux_cnt_r < MUX_ON_CYC)
      bank_mask = 5'b1_0101;
    else if (mux_cnt_r >= MUX_HALF_CYC && mux_cnt_r < MUX_HALF_CYC + MUX_ON_CYC)
      bank_mask = 5'b0_1010;
  end

  wire [4:0] shown_pat = first_empty_flag_r ? {pattern_r[4:1], blink_on_r}
                                            : pattern_r;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      led_segment_outputs <= 5'b0_0000;
      led_common_drive <= 1'b0;
      led_common_oe_n <= 1'b1;
    end
    else
    begin
      led_segment_outputs <= show_r ? (shown_pat & bank_mask) : 5'b0_0000;
      led_common_drive <= show_r && (bank_mask != 5'b0_0000);
      led_common_oe_n <= !(show_r && (bank_mask != 5'b0_0000));
    end
  end

  // ****************************************************************
  // apb registers and interrupt
  // ****************************************************************
  always @*
  begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      `LDD_REG_THRESH:
        rd_data[7:0] = empty_threshold_setting_r;
      `LDD_REG_CHGTHR:
        rd_data[15:0] = charge_detect_threshold_r;
      `LDD_REG_STATUS:
      begin
        rd_data[`LDD_ST_SHOW] = show_r;
        rd_data[`LDD_ST_FIRST] = first_empty_flag_r;
        rd_data[`LDD_ST_FINAL] = final_empty_flag_r;
        rd_data[`LDD_ST_CHG] = charging_r;
        rd_data[`LDD_ST_MODE_LO + 1 -: 2] = {req_low, req_high};
        rd_data[`LDD_ST_PAT_LO + 4 -: 5] = pattern_r;
        rd_data[`LDD_ST_TEMP_COMPENSATED_CHARGE_LO + 7 -: 8] = temp_compensated_charge;
      end
      `LDD_REG_IRQ_STAT:
        rd_data[`LDD_IRQ_W-1:0] = irq_stat_r;
      `LDD_REG_IRQ_MASK:
        rd_data[`LDD_IRQ_W-1:0] = irq_mask_r;
      default:
        rd_ok = 1'b0;
    endcase
  end

  reg first_empty_flag_q;
  reg final_empty_flag_q;
  wire [`LDD_IRQ_W-1:0] irq_ev = {timeout_ev,
                                  final_empty_flag_r & ~final_empty_flag_q,
                                  first_empty_flag_r & ~first_empty_flag_q};
  wire [`LDD_IRQ_W-1:0] irq_clr = (apb_wr && paddr == `LDD_REG_IRQ_STAT)
                                  ? pwdata[`LDD_IRQ_W-1:0] : {`LDD_IRQ_W{1'b0}};

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      empty_threshold_setting_r <= `LDD_THRESH_RST;
      charge_detect_threshold_r <= `LDD_CHGTHR_RST;
      irq_stat_r <= {`LDD_IRQ_W{1'b0}};
      irq_mask_r <= {`LDD_IRQ_W{1'b0}};
      first_empty_flag_q <= 1'b0;
      final_empty_flag_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      first_empty_flag_q <= first_empty_flag_r;
      final_empty_flag_q <= final_empty_flag_r;
      // one wait state: pready rises in the second access cycle
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_ok;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_data : 32'h0000_0000;
      if (apb_wr && paddr == `LDD_REG_THRESH)
        empty_threshold_setting_r <= pwdata[7:0];
      if (apb_wr && paddr == `LDD_REG_CHGTHR)
        charge_detect_threshold_r <= pwdata[15:0];
      if (apb_wr && paddr == `LDD_REG_IRQ_MASK)
        irq_mask_r <= pwdata[`LDD_IRQ_W-1:0];
      // a new event wins over a same-cycle clear
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

// File: bench/ldd_checker.sv
// port assertions for the capacity led display driver
`timescale 1ns/1ps
module ldd_checker (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // request pin and gauge values
  input wire display_request_input_req_high,
  input wire display_request_input_req_low,
  input wire [15:0] charge_sense,
  input wire [7:0] battery_voltage,
  input wire [7:0] learned_full_capacity,
  input wire [7:0] rate_compensated_charge,
  input wire temp_below_10c,
  // led pins, shown value, interrupt
  input wire [4:0] led_segment_outputs,
  input wire led_common_drive,
  input wire led_common_oe_n,
  input wire [7:0] temp_compensated_charge,
  input wire irq
);
  // ****
  // segments allowed by the shown charge
  // ****
  wire [10:0] q5 = 11'(temp_compensated_charge) * 11'd5;
  wire [10:0] c = {3'b000, learned_full_capacity};
  wire [4:1] pat = {q5 > c * 11'd4, q5 > c * 11'd3, q5 > c * 11'd2, q5 > c};
  wire [7:0] r = rate_compensated_charge;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_bank_split: assert property (!(|(led_segment_outputs & 5'h15)
    && |(led_segment_outputs & 5'h0a))) else $error("both banks lit");
  a_req_high_off: assert property (display_request_input_req_high [*8] |=>
    led_segment_outputs == 5'h00 && led_common_oe_n) else $error("lit while forced off");
  a_common_pair: assert property (led_common_oe_n == !led_common_drive)
    else $error("common enable disagrees");
  a_seg_common: assert property (|led_segment_outputs |-> led_common_drive)
    else $error("segment without common");
  a_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04,
    8'h08, 8'h0c, 8'h10}))
    else $error("slave error wrong");
  a_lit_pattern: assert property (($stable(temp_compensated_charge)
    && $stable(learned_full_capacity)) [*6] |-> (led_segment_outputs[4:1] & ~pat) == 4'h0)
    else $error("segment beyond charge");
  a_cold_derate: assert property (($stable(r) && $stable(temp_below_10c)) [*3]
    |-> temp_compensated_charge == (temp_below_10c ? r - (r >> 3) : r))
    else $error("shown charge wrong");
  cover property (led_common_drive && led_segment_outputs[1]);
  cover property (pready && pslverr);
  cover property (irq);
endmodule

bind ldd_top ldd_checker ldd_checker_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .display_request_input_req_high, .display_request_input_req_low, .charge_sense,
  .battery_voltage, .learned_full_capacity, .rate_compensated_charge, .temp_below_10c,
  .led_segment_outputs, .led_common_drive, .led_common_oe_n, .temp_compensated_charge, .irq);

// File: bench/ldd_led_model.sv
// led bar and request pin model for the capacity display
`timescale 1ns/1ps
module ldd_led_model (
  // bench control
  input wire clk,
  input wire clr,
  input wire [1:0] mode,
  // led pins of the driver
  input wire [4:0] led_segment_outputs,
  input wire led_common_drive,
  input wire led_common_oe_n,
  // request pin levels and what the leds showed
  output wire display_request_input_req_high,
  output wire display_request_input_req_low,
  output logic [4:0] seen,
  output int c0,
  output int c1,
  output int c2
);
  // ****
  // an led glows only when its segment sinks and the common sources
  // ****
  wire [4:0] lit = led_segment_outputs & {5{led_common_drive & ~led_common_oe_n}};
  // mode 1 ties the pin high, 2 pulls it low, 0 leaves it floating
  assign display_request_input_req_high = (mode == 2'd1);
  assign display_request_input_req_low = (mode == 2'd2);
  always @(posedge clk)
  begin
    seen <= clr ? 5'h00 : seen | lit;
    c0 <= clr ? 0 : c0 + lit[0];
    c1 <= clr ? 0 : c1 + lit[1];
    c2 <= clr ? 0 : c2 + lit[2];
  end
endmodule

// File: bench/capacity_led_display_driver_tb.sv
// self-checking bench for the capacity led display driver
`timescale 1ns/1ps
`include "ldd_defs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module capacity_led_display_driver_tb;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, cold = 0, clr = 0, err;
  logic [7:0] paddr = 0, bv = 8'hff, cap = 8'd100, rcc = 8'd100, m;
  logic [31:0] pwdata = 0, rd;
  logic [15:0] cs = 0;
  logic [1:0] mode = 0;
  wire [31:0] prdata;
  wire pready, pslverr, dh, dl, drv, oe_n, irq;
  wire [4:0] segs, seen;
  wire [7:0] tcc;
  int c0, c1, c2, failures = 0, checks = 0;
  ldd_top #(.MUX_CYC(100), .SHOW_CYC(2000), .BLINK_HALF_CYC(300)) ldd_top_i (.clk, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .display_request_input_req_high(dh), .display_request_input_req_low(dl), .charge_sense(cs), .battery_voltage(bv),
    .learned_full_capacity(cap), .rate_compensated_charge(rcc), .temp_below_10c(cold),
    .led_segment_outputs(segs), .led_common_drive(drv), .led_common_oe_n(oe_n),
    .temp_compensated_charge(tcc), .irq);
  ldd_led_model ldd_led_model_i (.clk, .clr, .mode, .led_segment_outputs(segs),
    .led_common_drive(drv), .led_common_oe_n(oe_n), .display_request_input_req_high(dh),
    .display_request_input_req_low(dl), .seen, .c0, .c1, .c2);
  // ****
  // expectations and bus tasks
  // ****
  function logic [7:0] etcc(input logic [7:0] r, input logic t);
    return t ? r - (r >> 3) : r;
  endfunction
  function logic [4:0] epat(input logic [7:0] q, input logic [7:0] f);
    for (int k = 0; k < 5; k++) epat[k] = 5 * q > k * f;
  endfunction
  task results;
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
    if (n >= 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // gather what the leds show over n cycles
  task look(input int n);
    clr <= 1;
    @(posedge clk) clr <= 0;
    // one edge more so the model's last count has landed
    wt(n + 1);
  endtask
  task setv(input logic [7:0] f, input logic [7:0] r, input logic t);
    cap <= f;
    rcc <= r;
    cold <= t;
    wt(12);
    `CHK(tcc, etcc(r, t))
    look(200);
    `CHK(seen, epat(etcc(r, t), f))
  endtask
  initial forever #4 clk = ~clk;
  initial
  begin
    #(8 * 40000);
    failures++;
    results;
  end
  initial
  begin
    void'($urandom(32'ha534));
    wt(4);
    reset_n <= 1;
    apb(0, `LDD_REG_THRESH, 0);
    `CHK(rd, 32'h0000_00a2)
    apb(0, `LDD_REG_CHGTHR, 0);
    `CHK(rd, 32'h0000_0002)
    apb(1, `LDD_REG_THRESH, 32'h0000_0055);
    apb(0, `LDD_REG_THRESH, 0);
    `CHK(rd, 32'h0000_0055)
    apb(1, `LDD_REG_THRESH, 32'h0000_00a2);
    apb(0, 8'h40, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    @(posedge clk) mode <= 2'd1;
    wt(10);
    cs <= 16'd100;
    look(200);
    `CHK(seen, 5'h00)
    cs <= 16'd0;
    mode <= 2'd0;
    look(200);
    `CHK(seen, 5'h00)
    cs <= 16'd100;
    setv(100, 100, 0);
    `CHK(c1, 60)
    `CHK(c2, 60)
    setv(100, 20, 0);
    setv(100, 21, 0);
    setv(100, 0, 1);
    repeat (8)
    begin
      m = 8'($urandom_range(255, 1));
      setv(m, 8'($urandom_range(m, 0)), 1'($urandom));
    end
    cap <= 100;
    rcc <= 100;
    cold <= 0;
    cs <= 16'd0;
    mode <= 2'd2;
    wt(1700);
    look(100);
    `CHK(seen, 5'h1f)
    wt(350);
    look(100);
    `CHK(seen, 5'h00)
    `CHK(irq, 1'b0)
    apb(1, `LDD_REG_IRQ_MASK, 32'h0000_0004);
    wt(2);
    `CHK(irq, 1'b1)
    apb(1, `LDD_REG_IRQ_STAT, 32'h0000_0004);
    wt(2);
    `CHK(irq, 1'b0)
    mode <= 2'd0;
    cs <= 16'd100;
    bv <= 8'ha0;
    wt(20);
    look(1200);
    `CHK(c0, 180)
    `CHK(c2, 360)
    bv <= 8'h90;
    wt(20);
    look(200);
    `CHK(seen, 5'h00)
    apb(0, `LDD_REG_STATUS, 0);
    `CHK(rd, 32'h0064_1f0e)
    apb(0, `LDD_REG_IRQ_STAT, 0);
    `CHK(rd, 32'h0000_0003)
    results;
  end
endmodule
